//--- src/una_top.sv
// module: nine-bit asynchronous serial port with classic Wishbone registers
// Notes on behaviour
// - frame: start, 8 data LSB first, ninth, stop
// - ninth transmitted bit from tx_ninth_bit
// - received ninth bit goes to rx_ninth_bit
// - bit rate is mclk/32 doubled, else mclk/64
// - buffer write starts at next slice rollover
// - each later bit at next rollover
// - stop bit after all nine data bits
// - tx_done_flag at eleventh rollover after write
// - no reception while receive enable low
// - falling edge starts frame, sixteen-fold monitoring; the code watches for the edge every clock
// - falling edge restarts the slice counter
// - bit value by majority of slices 8-10
// - start bit voted high aborts the frame
// - nine data shifts, then load on the stop bit vote
`timescale 1ns/100ps
`default_nettype none
module una_top (
	input wire logic mclk, // system clock, 25 MHz
	input wire logic rstn, // async reset, active low
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [4:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire logic rxd, // receive line, asynchronous
	output logic txd, // transmit line
	output logic irq // level interrupt
);
	// bus slave state
	logic ack_ff; // ack, one cycle
	logic [31:0] rdat_ff; // read data
	logic req; // new request this cycle
	logic wr_go; // write takes effect at the ack edge
	logic lane0; // low byte lane written
	// software state
	logic [una_pkg::CTRL_W-1:0] ctrl_ff; // control register
	logic [una_pkg::EVT_W-1:0] ien_ff; // event enables
	logic [una_pkg::EVT_W-1:0] sts_ff; // sticky events
	logic [una_pkg::EVT_W-1:0] evt_set; // events this cycle
	logic [una_pkg::EVT_W-1:0] evt_clr; // clear strobes
	logic irq_ff; // registered interrupt
	// transmitter
	logic tx_wr; // accepted buffer write
	logic tx_busy_ff; // frame in progress
	logic [10:0] tx_shift_ff; // frame still to send
	logic [3:0] tx_cnt_ff; // rollovers since the write
	logic txd_ff; // line register
	// receiver
	logic rx_s1_ff; // sync stage one
	logic rx_s2_ff; // sync stage two
	logic rx_prev_ff; // last synced level
	logic rx_fall; // high to low seen
	logic rx_go; // frame start
	una_pkg::una_rx_state_t rx_st_ff; // receive state
	una_pkg::una_rx_state_t nxt_rx_st; // next receive state
	logic [8:0] rx_shift_ff; // bits gathered, LSB first
	logic [3:0] rx_cnt_ff; // data bits gathered
	logic [7:0] rx_buf_ff; // received serial_buffer
	logic rx9_ff; // rx_ninth_bit
	logic rx_load; // frame accepted
	logic vote_bit; // voted bit
	logic vote_vld; // voted bit pulse

	una_slice_if tx_sl (); // transmit slice timing
	una_slice_if rx_sl (); // receive slice timing

	// both counters follow the same rate select
	assign tx_sl.dbl = ctrl_ff[una_pkg::CTRL_DBL];
	assign rx_sl.dbl = ctrl_ff[una_pkg::CTRL_DBL];
	// the transmit counter is free running; the write waits for it
	assign tx_sl.restart = 1'b0;
	assign rx_sl.restart = rx_go;

	una_slice_ctr u_tx_ctr (
		.mclk(mclk),
		.rstn(rstn),
		.sl(tx_sl)
	);

	una_slice_ctr u_rx_ctr (
		.mclk(mclk),
		.rstn(rstn),
		.sl(rx_sl)
	);

	una_voter u_voter (
		.mclk(mclk),
		.rstn(rstn),
		.sl(rx_sl),
		.din(rx_s2_ff),
		.bit_o(vote_bit),
		.vld_o(vote_vld)
	);

	// bus decode: ack one cycle after the request, write on the ack edge
	assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
	assign lane0 = wr_go & wb_sel_i[0];
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// acknowledge, dropped the cycle after it is given
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			ack_ff <= 1'b0;
		else
			ack_ff <= req;
	end

	// read mux, captured with the request; unmapped reads give zero
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdat_ff <= 32'h0;
		end else if (req && !wb_we_i) begin
			if (wb_adr_i == una_pkg::OFS_CTRL) begin
				rdat_ff <= {29'h0, ctrl_ff};
			end else if (wb_adr_i == una_pkg::OFS_DATA) begin
				rdat_ff <= {24'h0, rx_buf_ff};
			end else if (wb_adr_i == una_pkg::OFS_STAT) begin
				rdat_ff <= {27'h0, rx_st_ff != una_pkg::RX_IDLE, tx_busy_ff, rx9_ff, sts_ff};
			end else if (wb_adr_i == una_pkg::OFS_IEN) begin
				rdat_ff <= {30'h0, ien_ff};
			end else begin
				rdat_ff <= 32'h0;
			end
		end
	end

	// control and enable registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_ff <= una_pkg::CTRL_RST;
			ien_ff <= una_pkg::IEN_RST;
		end else if (lane0 && wb_adr_i == una_pkg::OFS_CTRL) begin
			ctrl_ff <= wb_dat_i[una_pkg::CTRL_W-1:0];
		end else if (lane0 && wb_adr_i == una_pkg::OFS_IEN) begin
			ien_ff <= wb_dat_i[una_pkg::EVT_W-1:0];
		end
	end

	// sticky events: a set in the clearing cycle survives
	assign evt_clr = (lane0 && wb_adr_i == una_pkg::OFS_ICLR) ?
		wb_dat_i[una_pkg::EVT_W-1:0] : 2'h0;
	assign evt_set = {rx_load, tx_busy_ff & tx_sl.roll & (tx_cnt_ff == una_pkg::TX_LAST)};

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			sts_ff <= 2'h0;
		else
			sts_ff <= (sts_ff & ~evt_clr) | evt_set;
	end

	// interrupt level from enabled events
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(sts_ff & ien_ff);
	end
	assign irq = irq_ff;

	// transmitter: a write while busy is dropped, the frame is not disturbed
	assign tx_wr = lane0 && wb_adr_i == una_pkg::OFS_DATA && !tx_busy_ff;
	assign txd = txd_ff;

	// frame image and bit counter
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_busy_ff <= 1'b0;
			tx_shift_ff <= 11'h7FF;
			tx_cnt_ff <= 4'h0;
		end else if (tx_wr) begin
			tx_busy_ff <= 1'b1;
			// stop, ninth, data LSB first, start
			tx_shift_ff <= {1'b1, ctrl_ff[una_pkg::CTRL_TX9], wb_dat_i[7:0], 1'b0};
			tx_cnt_ff <= 4'h0;
		end else if (tx_busy_ff && tx_sl.roll) begin
			tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
			tx_cnt_ff <= tx_cnt_ff + 4'h1;
			// stop bit goes out on the eleventh rollover; frame is done
			if (tx_cnt_ff == una_pkg::TX_LAST)
				tx_busy_ff <= 1'b0;
		end
	end

	// line changes only on a rollover, never at the write itself
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			txd_ff <= 1'b1;
		else if (tx_busy_ff && tx_sl.roll)
			txd_ff <= tx_shift_ff[0];
	end

	// receive line synchroniser and edge memory
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
		end else begin
			rx_s1_ff <= rxd;
			rx_s2_ff <= rx_s1_ff;
			rx_prev_ff <= rx_s2_ff;
		end
	end

	// edge watch runs every clock, finer than the sixteen-fold slice rate
	assign rx_fall = rx_prev_ff & ~rx_s2_ff;
	assign rx_go = (rx_st_ff == una_pkg::RX_IDLE) && ctrl_ff[una_pkg::CTRL_RX_EN] && rx_fall;
	// frame kept only if software has taken the last one
	assign rx_load = (rx_st_ff == una_pkg::RX_STOP) && vote_vld && !sts_ff[una_pkg::ST_RX_DONE];

	// receive sequence
	always_comb begin
		nxt_rx_st = rx_st_ff;
		case (rx_st_ff)
			una_pkg::RX_IDLE: begin
				if (rx_go)
					nxt_rx_st = una_pkg::RX_START;
			end
			una_pkg::RX_START: begin
				if (!ctrl_ff[una_pkg::CTRL_RX_EN])
					nxt_rx_st = una_pkg::RX_IDLE;
				else if (vote_vld && vote_bit)
					nxt_rx_st = una_pkg::RX_IDLE;
				else if (vote_vld)
					nxt_rx_st = una_pkg::RX_DATA;
			end
			una_pkg::RX_DATA: begin
				if (!ctrl_ff[una_pkg::CTRL_RX_EN])
					nxt_rx_st = una_pkg::RX_IDLE;
				else if (vote_vld && rx_cnt_ff == una_pkg::RX_LAST)
					nxt_rx_st = una_pkg::RX_STOP;
			end
			una_pkg::RX_STOP: begin
				if (!ctrl_ff[una_pkg::CTRL_RX_EN] || vote_vld)
					nxt_rx_st = una_pkg::RX_IDLE;
			end
			default: begin
				nxt_rx_st = una_pkg::RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			rx_st_ff <= una_pkg::RX_IDLE;
		else
			rx_st_ff <= nxt_rx_st;
	end

	// data shifter: newest bit enters at the top, so LSB lands at bit 0
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_shift_ff <= 9'h0;
			rx_cnt_ff <= 4'h0;
		end else if (rx_st_ff == una_pkg::RX_START) begin
			rx_cnt_ff <= 4'h0;
		end else if (rx_st_ff == una_pkg::RX_DATA && vote_vld) begin
			rx_shift_ff <= {vote_bit, rx_shift_ff[8:1]};
			rx_cnt_ff <= rx_cnt_ff + 4'h1;
		end
	end

	// buffer and ninth bit load on the stop bit vote after the ninth bit
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_buf_ff <= 8'h0;
			rx9_ff <= 1'b0;
		end else if (rx_load) begin
			rx_buf_ff <= rx_shift_ff[7:0];
			rx9_ff <= rx_shift_ff[8];
		end
	end

	property p_idle_high;
		@(posedge mclk) disable iff (!rstn)
		!tx_busy_ff && !$past(tx_busy_ff) |-> txd;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line low while idle");
	// start bit within one full slow rollover period of the write
	property p_start_late;
		@(posedge mclk) disable iff (!rstn)
		tx_wr |=> ##[1:64] !txd;
	endproperty
	a_start_late: assert property (p_start_late) else $error("start bit not on the rollover");
	property p_first_wait;
		@(posedge mclk) disable iff (!rstn)
		tx_wr |=> txd;
	endproperty
	a_first_wait: assert property (p_first_wait) else $error("start bit at the write");
	property p_on_roll;
		@(posedge mclk) disable iff (!rstn)
		$changed(txd) |-> $past(tx_sl.roll) && $past(tx_busy_ff);
	endproperty
	a_on_roll: assert property (p_on_roll) else $error("line moved off a rollover");
	property p_ninth;
		@(posedge mclk) disable iff (!rstn)
		tx_wr |=> tx_shift_ff[9] == $past(ctrl_ff[una_pkg::CTRL_TX9]);
	endproperty
	a_ninth: assert property (p_ninth) else $error("ninth bit not from control");
	property p_stop_done;
		@(posedge mclk) disable iff (!rstn)
		$rose(sts_ff[una_pkg::ST_TX_DONE]) |-> txd && $past(tx_cnt_ff) == una_pkg::TX_LAST;
	endproperty
	a_stop_done: assert property (p_stop_done) else $error("done flag not at stop bit");
	property p_rx_off;
		@(posedge mclk) disable iff (!rstn)
		!ctrl_ff[una_pkg::CTRL_RX_EN] |=> rx_st_ff == una_pkg::RX_IDLE;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receiving while disabled");
	property p_restart;
		@(posedge mclk) disable iff (!rstn)
		rx_go |=> rx_sl.slice == 4'h0 && rx_st_ff == una_pkg::RX_START;
	endproperty
	a_restart: assert property (p_restart) else $error("slice count not reset on edge");
	property p_abort;
		@(posedge mclk) disable iff (!rstn)
		rx_st_ff == una_pkg::RX_START && vote_vld && vote_bit |=> rx_st_ff == una_pkg::RX_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("bad start bit not dropped");
	property p_load;
		@(posedge mclk) disable iff (!rstn)
		rx_load |=> sts_ff[una_pkg::ST_RX_DONE] && rx9_ff == $past(rx_shift_ff[8])
			&& rx_buf_ff == $past(rx_shift_ff[7:0]);
	endproperty
	a_load: assert property (p_load) else $error("receive load wrong");
	property p_keep;
		@(posedge mclk) disable iff (!rstn)
		sts_ff[una_pkg::ST_RX_DONE] |=> $stable(rx_buf_ff) && $stable(rx9_ff);
	endproperty
	a_keep: assert property (p_keep) else $error("buffer overwritten while full");
endmodule
`default_nettype wire

//--- src/una_pkg.sv
// package: register map, field positions and timing counts of the serial port
`default_nettype none
package una_pkg;
	// register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00; // control
	localparam logic [4:0] OFS_DATA = 5'h04; // serial_buffer
	localparam logic [4:0] OFS_STAT = 5'h08; // status, read only
	localparam logic [4:0] OFS_ICLR = 5'h0C; // event clear, write only
	localparam logic [4:0] OFS_IEN = 5'h10; // event enable
	// control fields
	localparam int CTRL_RX_EN = 0; // receive enable
	localparam int CTRL_DBL = 1; // rate_double_sel
	localparam int CTRL_TX9 = 2; // tx_ninth_bit
	localparam int CTRL_W = 3;
	localparam logic [2:0] CTRL_RST = 3'h0;
	// status fields, the two events lowest
	localparam int ST_TX_DONE = 0; // tx_done_flag
	localparam int ST_RX_DONE = 1; // rx_done_flag
	localparam int ST_RX9 = 2; // rx_ninth_bit
	localparam int ST_TX_BUSY = 3;
	localparam int ST_RX_BUSY = 4;
	localparam int EVT_W = 2;
	localparam logic [1:0] IEN_RST = 2'h0;
	// clocks per slice: 16 slices of 2 or 4 clocks give 1/32 or 1/64 of mclk
	localparam int PRE_FAST = 2;
	localparam int PRE_SLOW = 4;
	localparam logic [3:0] SLICE_LAST = 4'hF;
	// vote samples in the 8th, 9th and 10th slice
	localparam logic [3:0] SMP_A = 4'h7;
	localparam logic [3:0] SMP_B = 4'h8;
	localparam logic [3:0] SMP_C = 4'h9;
	// frame: start, 8 data, ninth, stop
	localparam int FRAME_BITS = 11;
	localparam logic [3:0] TX_LAST = 4'hA; // index of the stop bit rollover
	localparam logic [3:0] RX_LAST = 4'h8; // index of the ninth data bit
	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} una_rx_state_t;
endpackage
`default_nettype wire

//--- src/una_slice_if.sv
// interface: one divide-by-16 slice counter and its users
`timescale 1ns/100ps
`default_nettype none
interface una_slice_if;
	logic dbl; // rate_double_sel
	logic restart; // zero prescaler and slice count
	logic tick; // one slice has elapsed
	logic roll; // tick on the last slice
	logic [3:0] slice; // current slice 0..15
	modport ctr (input dbl, input restart, output tick, output roll, output slice);
	modport tap (input tick, input slice);
endinterface
`default_nettype wire

//--- src/una_slice_ctr.sv
// module: oscillator prescaler and divide-by-16 bit-slice counter
`timescale 1ns/100ps
`default_nettype none
module una_slice_ctr #(
	parameter int DIV_FAST = una_pkg::PRE_FAST, // clocks per slice, doubled rate
	parameter int DIV_SLOW = una_pkg::PRE_SLOW // clocks per slice, normal rate
) (
	input wire logic mclk, // system clock
	input wire logic rstn, // async reset, active low
	una_slice_if.ctr sl // counter side
);
	// the three-bit prescaler cannot count beyond eight clocks a slice
	if (DIV_FAST < 1 || DIV_SLOW < 1 || DIV_FAST > 8 || DIV_SLOW > 8) begin : g_bad_div
		$error("prescaler divisors must lie in 1..8");
	end

	logic [2:0] pre_ff; // prescaler
	logic [3:0] slice_ff; // slice count
	logic pre_last; // prescaler at its last count

	// rate select picks the prescale length
	assign pre_last = sl.dbl ? (pre_ff == 3'(DIV_FAST - 1)) : (pre_ff == 3'(DIV_SLOW - 1));
	// a restart swallows the tick so a slice never comes early
	assign sl.tick = pre_last & ~sl.restart;
	assign sl.roll = sl.tick & (slice_ff == una_pkg::SLICE_LAST);
	assign sl.slice = slice_ff;

	// prescaler
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			pre_ff <= 3'h0;
		else if (sl.restart || pre_last)
			pre_ff <= 3'h0;
		else
			pre_ff <= pre_ff + 3'h1;
	end

	// slice counter wraps after 16
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			slice_ff <= 4'h0;
		else if (sl.restart)
			slice_ff <= 4'h0;
		else if (sl.tick)
			slice_ff <= slice_ff + 4'h1;
	end

	property p_slow_rate;
		@(posedge mclk) disable iff (!rstn)
		sl.tick && !sl.dbl |=> (!sl.tick || sl.dbl) [*3];
	endproperty
	a_slow_rate: assert property (p_slow_rate) else $error("slice tick too early at /64");

	property p_fast_rate;
		@(posedge mclk) disable iff (!rstn)
		sl.tick && sl.dbl && !sl.restart |=>
			!sl.tick ##1 (sl.tick || sl.restart || $past(sl.restart) || !sl.dbl);
	endproperty
	a_fast_rate: assert property (p_fast_rate) else $error("slice tick spacing wrong at /32");
endmodule
`default_nettype wire

//--- src/una_voter.sv
// module: two-of-three bit voter on slices 8, 9 and 10
`timescale 1ns/100ps
`default_nettype none
module una_voter (
	input wire logic mclk, // system clock
	input wire logic rstn, // async reset, active low
	una_slice_if.tap sl, // receive slice counter
	input wire logic din, // synchronised receive line
	output logic bit_o, // voted bit
	output logic vld_o // one-cycle pulse, bit_o fresh
);
	logic smp_a_ff; // sample in slice 8
	logic smp_b_ff; // sample in slice 9
	logic bit_ff; // voted value
	logic vld_ff; // vote pulse

	assign bit_o = bit_ff;
	assign vld_o = vld_ff;

	// early samples, kept until the vote
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			smp_a_ff <= 1'b1;
			smp_b_ff <= 1'b1;
		end else if (sl.tick && sl.slice == una_pkg::SMP_A) begin
			smp_a_ff <= din;
		end else if (sl.tick && sl.slice == una_pkg::SMP_B) begin
			smp_b_ff <= din;
		end
	end

	// majority on the third sample; a single glitch cannot flip a bit
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bit_ff <= 1'b1;
			vld_ff <= 1'b0;
		end else begin
			vld_ff <= sl.tick && sl.slice == una_pkg::SMP_C;
			if (sl.tick && sl.slice == una_pkg::SMP_C)
				bit_ff <= (smp_a_ff & smp_b_ff) | (smp_a_ff & din) | (smp_b_ff & din);
		end
	end

	property p_vote;
		@(posedge mclk) disable iff (!rstn)
		sl.tick && sl.slice == una_pkg::SMP_C |=>
			vld_o && bit_o == (($past(smp_a_ff) + $past(smp_b_ff) + $past(din)) >= 2'd2);
	endproperty
	a_vote: assert property (p_vote) else $error("vote not majority of three");
endmodule
`default_nettype wire

//--- tb/una_remote.sv
// model: remote nine-bit asynchronous transceiver on the far side of the port
`timescale 1ns/100ps
`default_nettype none
module una_remote (
	input wire logic mclk, // system clock
	input wire logic txd, // line from the port
	output var logic rxd // line into the port
);
	int bit_clk = 64; // clocks per bit, set by the bench
	int frames = 0; // frames seen on txd
	int got_bt; // clocks from start edge to first rise
	time t_fall; // time of the start edge
	logic [10:0] sh; // sampled frame, start lowest
	logic [8:0] got; // nine data bits
	logic got_start; // start level
	logic got_stop; // stop level
	// idle line high; the line is always driven, never released
	initial rxd = 1'b1;
	// receiver: samples each bit in its middle, counts the first bit length
	always begin
		@(negedge txd);
		t_fall = $time;
		got_bt = 0;
		for (int c = 0; c <= bit_clk * 21 / 2; c++) begin
			@(posedge mclk);
			if (got_bt == 0 && txd === 1'b1) begin
				got_bt = c;
			end
			if (c % bit_clk == bit_clk / 2) begin
				sh[c / bit_clk] = txd;
			end
		end
		got_start = sh[0];
		got = sh[9:1];
		got_stop = sh[10];
		frames++;
	end
	// one frame; glitch flips the first vote sample of each data bit, not the other two
	task automatic send_frame(input logic [8:0] d, input bit glitch);
		logic [10:0] f;
		bit g;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			for (int c = 0; c < bit_clk; c++) begin
				g = glitch && i > 0 && i < 10 && c >= bit_clk * 7 / 16 && c < bit_clk * 9 / 16;
				@(posedge mclk);
				rxd <= f[i] ^ g;
			end
		end
	endtask
	// short low pulse, too short to pass as a start bit
	task automatic pulse_low(input int n);
		@(posedge mclk);
		rxd <= 1'b0;
		repeat (n) @(posedge mclk);
		rxd <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// testbench: register, transmit and receive checks of the serial port
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
	end \
end
module tb;
	logic mclk; // 25 MHz
	logic rstn; // reset, active low
	logic wb_cyc; // bus cycle
	logic wb_stb; // strobe
	logic wb_we; // write
	logic [4:0] wb_adr; // address
	logic [3:0] wb_sel; // lanes
	logic [31:0] wb_dat; // write data
	logic [31:0] wb_q; // read data
	logic wb_ack; // acknowledge
	wire rxd; // line into the port
	logic txd; // line out
	logic irq; // interrupt
	int fail_count = 0; // mismatches
	int tests_run = 0; // comparisons
	time t_ack; // edge of the last ack
	una_top dut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_q), .wb_ack_o(wb_ack), .rxd(rxd), .txd(txd), .irq(irq));
	una_remote far (.mclk(mclk), .txd(txd), .rxd(rxd));
	// clock, 40 ns period
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// verdict and end of run
	task automatic results();
		$display("comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one classic cycle; entered just after a rising edge
	task automatic wb_cycle(input logic we, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'hF;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			results();
		end
		q = wb_q;
		t_ack = $time;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wb_wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_cycle(1'b1, a, d, q);
	endtask
	task automatic wb_rd(input logic [4:0] a, output logic [31:0] q);
		wb_cycle(1'b0, a, 32'h0, q);
	endtask
	// one transmitted frame, with a refused write while busy
	task automatic tx_case(input logic [2:0] ctl, input logic [8:0] d, input int bc);
		logic [31:0] q;
		int n;
		int fr;
		time t_wr;
		time t_irq;
		far.bit_clk = bc;
		fr = far.frames;
		wb_wr(una_pkg::OFS_CTRL, {29'h0, ctl});
		wb_wr(una_pkg::OFS_DATA, {24'h0, d[7:0]});
		t_wr = t_ack;
		wb_rd(una_pkg::OFS_STAT, q);
		`CHK(q[una_pkg::ST_TX_BUSY], 1'b1)
		wb_wr(una_pkg::OFS_DATA, 32'h0000_00FF);
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 2000) begin
			fail_count++;
			results();
		end
		t_irq = $time;
		repeat (bc * 3) @(posedge mclk);
		`CHK(far.got_start, 1'b0)
		`CHK(far.got, d)
		`CHK(far.got_stop, 1'b1)
		`CHK(far.got_bt, bc)
		`CHK((far.t_fall - t_wr) / 40 inside {[1:bc]}, 1'b1)
		// flag one cycle after the eleventh rollover, interrupt one more
		`CHK((t_irq - far.t_fall) / 40 - 10 * bc, 2)
		repeat (bc * 12) @(posedge mclk);
		`CHK(far.frames, fr + 1)
		wb_wr(una_pkg::OFS_ICLR, 32'h1);
		@(posedge mclk);
		`CHK(irq, 1'b0)
	endtask
	// one received frame, then data, ninth bit and interrupt
	task automatic rx_chk(input logic [8:0] d, input bit gl, input logic ei,
		input logic [8:0] ed);
		logic [31:0] q;
		far.send_frame(d, gl);
		repeat (4) @(posedge mclk);
		`CHK(irq, ei)
		wb_rd(una_pkg::OFS_DATA, q);
		`CHK(q[7:0], ed[7:0])
		wb_rd(una_pkg::OFS_STAT, q);
		`CHK(q[una_pkg::ST_RX9], ed[8])
	endtask
	// main sequence
	initial begin
		logic [31:0] q;
		rstn = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 5'h00;
		wb_sel = 4'hF;
		wb_dat = 32'h0;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		`CHK(txd, 1'b1)
		`CHK(irq, 1'b0)
		wb_rd(una_pkg::OFS_CTRL, q);
		`CHK(q, 32'h0)
		wb_rd(una_pkg::OFS_IEN, q);
		`CHK(q, 32'h0)
		// unmapped and read-only places ignore writes
		wb_wr(5'h14, 32'h0000_00FF);
		wb_rd(5'h14, q);
		`CHK(q, 32'h0)
		wb_wr(una_pkg::OFS_STAT, 32'h0000_00FF);
		wb_rd(una_pkg::OFS_STAT, q);
		`CHK(q, 32'h0)
		wb_wr(una_pkg::OFS_IEN, 32'h1);
		tx_case(3'h6, 9'h1A5, 32);
		tx_case(3'h0, 9'h03D, 64);
		far.bit_clk = 64;
		wb_wr(una_pkg::OFS_IEN, 32'h2);
		wb_wr(una_pkg::OFS_CTRL, 32'h1);
		rx_chk(9'h15A, 1'b0, 1'b1, 9'h15A);
		rx_chk(9'h0C3, 1'b0, 1'b1, 9'h15A);
		// masking holds the line low while the flag stays set
		wb_wr(una_pkg::OFS_IEN, 32'h0);
		@(posedge mclk);
		`CHK(irq, 1'b0)
		wb_wr(una_pkg::OFS_IEN, 32'h2);
		@(posedge mclk);
		`CHK(irq, 1'b1)
		wb_wr(una_pkg::OFS_ICLR, 32'h2);
		rx_chk(9'h081, 1'b1, 1'b1, 9'h081);
		wb_wr(una_pkg::OFS_ICLR, 32'h2);
		far.pulse_low(16);
		repeat (64 * 12) @(posedge mclk);
		`CHK(irq, 1'b0)
		rx_chk(9'h1E7, 1'b0, 1'b1, 9'h1E7);
		wb_wr(una_pkg::OFS_ICLR, 32'h2);
		// receive at the doubled rate too, glitch on every data bit
		wb_wr(una_pkg::OFS_CTRL, 32'h3);
		far.bit_clk = 32;
		rx_chk(9'h1B4, 1'b1, 1'b1, 9'h1B4);
		wb_wr(una_pkg::OFS_ICLR, 32'h2);
		wb_wr(una_pkg::OFS_CTRL, 32'h0);
		rx_chk(9'h018, 1'b0, 1'b0, 9'h1B4);
		results();
	end
endmodule
`default_nettype wire
